//--- core/cmc_pkg.sv
// constants and types shared by the core memory board control logic
package cmc_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 16;
	// word-address bits inside a board of each capacity
	localparam int WORD_BITS_16K = 14;
	localparam int WORD_BITS_8K = 13;
	localparam int WORD_BITS_4K = 12;
	// memory timing clock and the two cycle lengths, in ns
	localparam int MEM_CLK_PERIOD_NS = 100;
	localparam int CYCLE_FAST_NS = 800;
	localparam int CYCLE_SLOW_NS = 1000;
	localparam int CYCLE_FAST_TICKS = CYCLE_FAST_NS / MEM_CLK_PERIOD_NS;
	localparam int CYCLE_SLOW_TICKS = CYCLE_SLOW_NS / MEM_CLK_PERIOD_NS;
	// memory clock tick of the fetch half at which sense data is taken
	localparam int STROBE_TICK = 3;
	localparam int TICK_W = 4;
	localparam logic [TICK_W-1:0] TICK_ZERO = 4'h0;
	localparam logic [TICK_W-1:0] TICK_ONE = 4'h1;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
	typedef enum logic [1:0] {CMC_IDLE, CMC_READ, CMC_PAUSE, CMC_WRITE} cmc_state_e;
endpackage : cmc_pkg

//--- core/cmc_select.sv
// board selection from the high-order word-address bits
`timescale 1ns/1ps
module cmc_select #(
	parameter int SEL_W = 3,
	parameter logic [SEL_W-1:0] SEL_MATCH = '0
) (
	// address and strap inputs
	input wire logic [SEL_W-1:0] high_addr_i,
	input wire logic board_select_block_i,
	input wire logic forced_select_i,
	// result
	output logic hit_o
);
	logic [SEL_W-1:0] term;

	// each bit is taken true or inverted so the and-term matches one segment only
	assign term = ~(high_addr_i ^ SEL_MATCH); // RQ18
	// block wins over force and address; force wins over address
	assign hit_o = !board_select_block_i && (forced_select_i || (&term)); // RQ17 RQ19 RQ20
endmodule : cmc_select

//--- core/cmc_mem_buf.sv
// memory buffer register holding the word between fetch and write halves
`timescale 1ns/1ps
module cmc_mem_buf #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// load port
	input wire logic load_i,
	input wire logic [W-1:0] d_i,
	// stored word
	output logic [W-1:0] q_o
);
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			q_o <= '0;
		else if (load_i)
			q_o <= d_i;
	end
endmodule : cmc_mem_buf

//--- core/cmc_core.sv
// control logic of one core memory board on the processor memory bus
// Operation
// [RQ1] data moves both ways on one sixteen-bit shared data bus
// [RQ2] processor drives a fifteen-bit word address bus to the boards
// [RQ3] cycle start request starts the selected board's cycle timing generator
// [RQ4] pause request sets hold flag; cycle stops after the read half
// [RQ5] processor asserts cycle finish to resume a paused cycle's write half
// [RQ6] processor asserts write when the bus word is to be stored
// [RQ7] sync hold, active low, from cycle start until read data is ready
// [RQ8] shared wait held until this board finishes its write half
// [RQ9] all cycle timing derives from the 10MHz memory timing clock
// [RQ10] cycle is fetch half then write half, 800ns or 1000ns long
// [RQ11] read samples sense outputs at strobe time into the buffer
// [RQ12] write access gives no strobe; buffer clocks the incoming word
// [RQ13] sense pulse means core held zero; buffer loads inverted sense
// [RQ14] write half drives toward zero; inhibit bits that stay one
// [RQ15] buffered address decodes to one X and one Y read drive
// [RQ16] 32K word space; board covers 4K, 8K or 16K; low bits pick word
// [RQ17] select compares one, two or three topmost address bits
// [RQ18] select is the and of bits taken true or inverted per strap
// [RQ19] select block input stops any response whatever the address
// [RQ20] forced select makes the board respond regardless of address
// [RQ21] buffer load block input prevents loading the buffer register
// [RQ22] direct buffer load stores the bus word without a memory cycle
// [RQ23] after reset generator idle, hold clear, wait and sync released
`timescale 1ns/1ps
module cmc_core #(
	parameter int WORD_BITS = cmc_pkg::WORD_BITS_4K,
	parameter logic [2:0] SEL_MATCH = 3'h0,
	parameter bit SLOW_CYCLE = 1'b0
) (
	// clock and reset
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// memory timing clock from the processor, sampled as an ordinary input
	input wire logic mem_clk_i,
	// processor requests
	input wire logic cycle_start_req_i,
	input wire logic rmw_pause_req_i,
	input wire logic cycle_finish_i,
	input wire logic write_i,
	input wire logic [cmc_pkg::ADDR_W-1:0] word_address_bus_i,
	// data bus, two-way
	input wire logic [cmc_pkg::DATA_W-1:0] data_i,
	output logic [cmc_pkg::DATA_W-1:0] data_o,
	output logic data_oe_n_o,
	// selection and buffer straps
	input wire logic board_select_block_i,
	input wire logic forced_select_i,
	input wire logic buffer_load_block_i,
	input wire logic direct_buffer_load_i,
	// handshakes back to the processor and other boards
	output logic sync_enable_n_o,
	input wire logic bus_wait_n_i,
	output logic bus_wait_n_o,
	output logic bus_wait_oe_n_o,
	// core array drive
	input wire logic [cmc_pkg::DATA_W-1:0] sense_i,
	output logic strobe_o,
	output logic [(1<<(WORD_BITS/2))-1:0] x_read_drive_o,
	output logic [(1<<(WORD_BITS-WORD_BITS/2))-1:0] y_read_drive_o,
	output logic write_drive_o,
	output logic [cmc_pkg::DATA_W-1:0] inhibit_o
);
	localparam int SEL_W = cmc_pkg::ADDR_W - WORD_BITS;
	localparam int XW = WORD_BITS / 2;
	localparam int YW = WORD_BITS - XW;
	localparam int TOTAL = SLOW_CYCLE ? cmc_pkg::CYCLE_SLOW_TICKS : cmc_pkg::CYCLE_FAST_TICKS;
	localparam logic [cmc_pkg::TICK_W-1:0] LAST_TICK = 4'(TOTAL - 1);
	localparam logic [cmc_pkg::TICK_W-1:0] HALF_LAST_TICK = 4'(TOTAL / 2 - 1);
	localparam logic [cmc_pkg::TICK_W-1:0] STROBE_AT = 4'(cmc_pkg::STROBE_TICK);

	// one-hot line decode used for both X and Y drive
	function automatic logic [(1<<YW)-1:0] line_decode(input logic [YW-1:0] idx);
		logic [(1<<YW)-1:0] v;
		v = '0;
		v[idx] = 1'b1;
		return v;
	endfunction : line_decode

	cmc_pkg::cmc_state_e state_q;
	logic [cmc_pkg::TICK_W-1:0] tick_q;
	logic mclk_q;
	logic mem_edge;
	logic req_q;
	logic start_go;
	logic sel_hit;
	logic hold_q;
	logic write_q;
	logic sync_hold_q;
	logic wait_q;
	logic rd_drive_q;
	logic strobe_ev;
	logic half_end;
	logic cycle_end;
	logic resume;
	logic [WORD_BITS-1:0] addr_q;
	logic buf_load;
	logic [cmc_pkg::DATA_W-1:0] buf_d;
	logic [cmc_pkg::DATA_W-1:0] buf_q;
	logic [(1<<YW)-1:0] x_dec;
	logic [(1<<YW)-1:0] y_dec;

	cmc_select #(
		.SEL_W(SEL_W),
		.SEL_MATCH(SEL_MATCH[SEL_W-1:0])
	) u_select (
		.high_addr_i(word_address_bus_i[cmc_pkg::ADDR_W-1:WORD_BITS]), // RQ16
		.board_select_block_i(board_select_block_i),
		.forced_select_i(forced_select_i),
		.hit_o(sel_hit)
	);

	cmc_mem_buf #(
		.W(cmc_pkg::DATA_W)
	) u_buf (
		.sys_clk_i(sys_clk_i),
		.arst_n_i(arst_n_i),
		.load_i(buf_load),
		.d_i(buf_d),
		.q_o(buf_q)
	);

	// memory clock rising edges are the only time base of the cycle
	assign mem_edge = mem_clk_i && !mclk_q; // RQ9
	// start on the request's rising edge so a held request does not rerun the cycle
	assign start_go = (state_q == cmc_pkg::CMC_IDLE) && cycle_start_req_i && !req_q
		&& sel_hit && bus_wait_n_i; // RQ3 RQ8
	assign strobe_ev = (state_q == cmc_pkg::CMC_READ) && mem_edge && (tick_q == STROBE_AT);
	assign half_end = (state_q == cmc_pkg::CMC_READ) && mem_edge && (tick_q == HALF_LAST_TICK);
	assign cycle_end = (state_q == cmc_pkg::CMC_WRITE) && mem_edge && (tick_q == LAST_TICK);
	assign resume = (state_q == cmc_pkg::CMC_PAUSE) && cycle_finish_i; // RQ5

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			mclk_q <= 1'b0;
			req_q <= 1'b0;
		end
		else
		begin
			mclk_q <= mem_clk_i;
			req_q <= cycle_start_req_i;
		end
	end

	// cycle sequencer: fetch half, optional pause, write half
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			state_q <= cmc_pkg::CMC_IDLE; // RQ23
		else
		begin
			unique case (state_q)
				cmc_pkg::CMC_IDLE:
					if (start_go)
						state_q <= cmc_pkg::CMC_READ; // RQ3
				cmc_pkg::CMC_READ:
					if (half_end)
						state_q <= (hold_q || rmw_pause_req_i) ? cmc_pkg::CMC_PAUSE
							: cmc_pkg::CMC_WRITE; // RQ4 RQ10
				cmc_pkg::CMC_PAUSE:
					if (resume)
						state_q <= cmc_pkg::CMC_WRITE; // RQ5
				cmc_pkg::CMC_WRITE:
					if (cycle_end)
						state_q <= cmc_pkg::CMC_IDLE; // RQ10
			endcase
		end
	end

	// tick count of memory clock edges; frozen while paused
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			tick_q <= cmc_pkg::TICK_ZERO;
		else if (start_go)
			tick_q <= cmc_pkg::TICK_ZERO;
		else if (mem_edge && (state_q == cmc_pkg::CMC_READ || state_q == cmc_pkg::CMC_WRITE))
			tick_q <= tick_q + cmc_pkg::TICK_ONE; // RQ9
	end

	// pause hold flag: only cleared by resuming, set only before the write half
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			hold_q <= 1'b0; // RQ23
		else if ((start_go || state_q == cmc_pkg::CMC_READ) && rmw_pause_req_i)
			hold_q <= 1'b1; // RQ4
		else if (resume)
			hold_q <= 1'b0;
	end

	// access direction and latched word address
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			write_q <= 1'b0;
			addr_q <= '0;
		end
		else if (start_go)
		begin
			write_q <= write_i; // RQ6
			addr_q <= word_address_bus_i[WORD_BITS-1:0]; // RQ2 RQ16
		end
		else if (resume)
			write_q <= write_i; // RQ6
	end

	// processor sync hold and shared wait
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sync_hold_q <= 1'b0; // RQ23
			wait_q <= 1'b0; // RQ23
		end
		else
		begin
			if (start_go)
				sync_hold_q <= 1'b1; // RQ7
			else if (strobe_ev)
				sync_hold_q <= 1'b0; // RQ7
			if (start_go)
				wait_q <= 1'b1; // RQ8
			else if (cycle_end)
				wait_q <= 1'b0; // RQ8
		end
	end

	// read data stays on the bus from strobe until the write half starts, or until idle if unpaused and the strobe tick is the fetch half's last tick
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			rd_drive_q <= 1'b0;
		else if (strobe_ev && !write_q)
			rd_drive_q <= 1'b1; // RQ1
		else if (state_q == cmc_pkg::CMC_IDLE || (half_end && !(hold_q || rmw_pause_req_i)) || resume)
			rd_drive_q <= 1'b0;
	end

	// buffer sources: inverted sense, bus word on write or on resume with write, direct load when idle
	always_comb
	begin
		buf_d = data_i;
		buf_load = 1'b0;
		if (strobe_ev)
		begin
			buf_load = 1'b1;
			if (!write_q)
				buf_d = ~sense_i; // RQ11 RQ13
		end
		else if (resume && write_i)
			buf_load = 1'b1; // RQ12
		else if (state_q == cmc_pkg::CMC_IDLE && !start_go && direct_buffer_load_i)
			buf_load = 1'b1; // RQ22
		if (buffer_load_block_i)
			buf_load = 1'b0; // RQ21
	end

	assign x_dec = line_decode(YW'(addr_q[XW-1:0]));
	assign y_dec = line_decode(addr_q[WORD_BITS-1:XW]);

	// array drives; inhibit keeps a core at one where the buffer bit is one
	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			strobe_o <= 1'b0;
			x_read_drive_o <= '0;
			y_read_drive_o <= '0;
			write_drive_o <= 1'b0;
		end
		else
		begin
			strobe_o <= strobe_ev && !write_q; // RQ11 RQ12
			if (state_q == cmc_pkg::CMC_READ && !half_end)
			begin
				x_read_drive_o <= x_dec[(1<<XW)-1:0]; // RQ15
				y_read_drive_o <= y_dec; // RQ15
			end
			else
			begin
				x_read_drive_o <= '0;
				y_read_drive_o <= '0;
			end
			write_drive_o <= (state_q == cmc_pkg::CMC_WRITE) && !cycle_end; // RQ14
		end
	end

	assign inhibit_o = write_drive_o ? buf_q : cmc_pkg::DATA_ZERO; // RQ14
	assign data_o = buf_q;
	// let go of the bus as soon as finish is seen, so the processor's word reaches the buffer at resume
	assign data_oe_n_o = !rd_drive_q || resume; // RQ1
	assign sync_enable_n_o = !sync_hold_q; // RQ7
	// open-drain wait: only ever pulls low
	assign bus_wait_n_o = 1'b0;
	assign bus_wait_oe_n_o = !wait_q; // RQ8

	sync_hold_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ7
		start_go |=> !sync_enable_n_o && !bus_wait_oe_n_o)
		else $error("sync hold or wait not raised at cycle start");

	sync_release_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ7
		strobe_ev |=> sync_enable_n_o)
		else $error("sync hold not released at strobe");

	wait_end_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ8
		(state_q != cmc_pkg::CMC_IDLE) |-> !bus_wait_oe_n_o)
		else $error("wait dropped before write half finished");

	select_block_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ19
		(board_select_block_i && state_q == cmc_pkg::CMC_IDLE) |=> state_q == cmc_pkg::CMC_IDLE)
		else $error("blocked board started a cycle");

	load_block_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ21
		buffer_load_block_i |=> buf_q == $past(buf_q))
		else $error("buffer loaded while blocked");

	direct_load_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ22
		(direct_buffer_load_i && !buffer_load_block_i && state_q == cmc_pkg::CMC_IDLE && !start_go)
		|=> (buf_q == $past(data_i)) && (state_q == cmc_pkg::CMC_IDLE))
		else $error("direct load failed or started a cycle");

	read_polarity_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ13
		(strobe_ev && !write_q && !buffer_load_block_i) |=> buf_q == ~$past(sense_i))
		else $error("buffer not loaded with inverted sense");

	write_no_strobe_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ12
		(strobe_ev && write_q) |=> !strobe_o)
		else $error("strobe pulsed on write access");

	pause_stop_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ4
		(state_q == cmc_pkg::CMC_PAUSE && !cycle_finish_i) |=> state_q == cmc_pkg::CMC_PAUSE && !write_drive_o)
		else $error("paused cycle moved without finish");

	inhibit_bits_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ14
		((inhibit_o & ~data_o) == cmc_pkg::DATA_ZERO) && (!write_drive_o -> inhibit_o == cmc_pkg::DATA_ZERO)
		&& (!write_drive_o || state_q == cmc_pkg::CMC_WRITE))
		else $error("inhibit or write drive outside the write half");

	drive_onehot_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ15
		(x_read_drive_o != '0) |-> $onehot(x_read_drive_o) && $onehot(y_read_drive_o))
		else $error("more than one drive line enabled");

	cycle_end_a: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i) // RQ10
		cycle_end |=> state_q == cmc_pkg::CMC_IDLE ##1 bus_wait_oe_n_o)
		else $error("cycle did not end after last tick");

	read_cycle_c: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		start_go && !write_i ##[1:400] strobe_ev ##[1:800] cycle_end);
	write_cycle_c: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		start_go && write_i ##[1:1000] cycle_end);
	rmw_cycle_c: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		state_q == cmc_pkg::CMC_PAUSE ##[1:100] resume);
	direct_load_c: cover property (@(posedge sys_clk_i) disable iff (!arst_n_i)
		direct_buffer_load_i && buf_load && state_q == cmc_pkg::CMC_IDLE);
endmodule : cmc_core

//--- sim/cmc_cpu_model.sv
// processor-side model: memory timing clock and memory bus requests
`timescale 1ns/1ps
module cmc_cpu_model (
	// clock
	input wire logic sys_clk_i,
	// memory bus toward the board
	output logic mem_clk_o,
	output logic start_o,
	output logic rmw_o,
	output logic fin_o,
	output logic wr_o,
	output logic [14:0] addr_o,
	output logic [15:0] data_o,
	output logic oe_n_o
);
	initial
	begin
		{start_o, rmw_o, fin_o, wr_o, oe_n_o} = 5'h01;
		addr_o = 15'h0000;
		data_o = 16'h0000;
		mem_clk_o = 1'b0;
		// free-running square wave; offset so no edge meets a system clock edge
		#3;
		forever #50 mem_clk_o = ~mem_clk_o;
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask : step
	task automatic put(input logic w, input logic [15:0] d);
		wr_o = w;
		data_o = d;
		oe_n_o = ~w;
	endtask : put
	// held two cycles: the board only looks at the rising edge
	task automatic start(input logic [14:0] a, input logic w, input logic [15:0] d, input logic r);
		step(1);
		addr_o = a;
		put(w, d);
		rmw_o = r;
		start_o = 1'b1;
		step(2);
		start_o = 1'b0;
	endtask : start
	task automatic finish(input logic w, input logic [15:0] d);
		step(1);
		put(w, d);
		rmw_o = 1'b0;
		fin_o = 1'b1;
		step(2);
		fin_o = 1'b0;
	endtask : finish
endmodule : cmc_cpu_model

//--- sim/cmc_core_test.sv
// self-checking bench of the core memory board control
`timescale 1ns/1ps
module cmc_core_test;
	logic sys_clk, arst_n, mem_clk, start, rmw, fin, wr, cpu_oe_n, strobe, wd, doe_n, sync_n, wt_n, wt_oe_n;
	logic blk = 1'b0, frc = 1'b0, lblk = 1'b0, dld = 1'b0, other_n = 1'b1, wd_seen, sync_at_str;
	logic [14:0] addr;
	logic [15:0] cpu_d, dut_d, bus, inh, inh_seen, sense = 16'h0000, bus_last = 16'h0000;
	logic [63:0] xd, yd;
	wire logic wt_in;
	int n_errors = 0, checked = 0, cyc = 0, n_strobe = 0;
	// undriven bus shows a changing pattern rather than a stale word
	assign bus = !doe_n ? dut_d : (!cpu_oe_n ? cpu_d : ~bus_last);
	assign wt_in = (wt_oe_n ? 1'b1 : wt_n) & other_n;
	cmc_cpu_model i_cpu (.sys_clk_i(sys_clk), .mem_clk_o(mem_clk), .start_o(start), .rmw_o(rmw), .fin_o(fin),
		.wr_o(wr), .addr_o(addr), .data_o(cpu_d), .oe_n_o(cpu_oe_n));
	cmc_core #(.WORD_BITS(cmc_pkg::WORD_BITS_4K), .SEL_MATCH(3'h0), .SLOW_CYCLE(1'b0)) i_dut (
		.sys_clk_i(sys_clk), .arst_n_i(arst_n), .mem_clk_i(mem_clk), .cycle_start_req_i(start),
		.rmw_pause_req_i(rmw), .cycle_finish_i(fin), .write_i(wr), .word_address_bus_i(addr),
		.data_i(bus), .data_o(dut_d), .data_oe_n_o(doe_n), .board_select_block_i(blk),
		.forced_select_i(frc), .buffer_load_block_i(lblk), .direct_buffer_load_i(dld),
		.sync_enable_n_o(sync_n), .bus_wait_n_i(wt_in), .bus_wait_n_o(wt_n), .bus_wait_oe_n_o(wt_oe_n),
		.sense_i(sense), .strobe_o(strobe), .x_read_drive_o(xd), .y_read_drive_o(yd),
		.write_drive_o(wd), .inhibit_o(inh));
	initial
	begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		bus_last <= bus;
		cyc <= cyc + 1;
		if (strobe === 1'b1)
		begin
			n_strobe <= n_strobe + 1;
			sync_at_str <= sync_n;
		end
		if (wd === 1'b1)
		begin
			wd_seen <= 1'b1;
			inh_seen <= inh;
		end
	end
	always @(posedge sys_clk)
	begin
		if (cyc == 5000)
		begin
			n_errors++;
			finish_test();
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic clr();
		n_strobe = 0;
		wd_seen = 1'b0;
		inh_seen = 16'h0000;
	endtask : clr
	task automatic wait_done(output int n);
		n = 0;
		while (wt_oe_n !== 1'b1 && n < 400)
		begin
			step(1);
			n++;
		end
	endtask : wait_done
	task automatic t_reset();
		chk("sync", 1, sync_n);
		chk("wait_oe", 1, wt_oe_n);
		chk("data_oe", 1, doe_n);
		chk("wdrive", 0, wd);
	endtask : t_reset
	task automatic t_read();
		int n;
		clr();
		sense = 16'h1234;
		i_cpu.start(15'h0a5b, 1'b0, 16'h0000, 1'b0);
		step(2);
		chk("sync", 0, sync_n);
		chk("wait_oe", 0, wt_oe_n);
		chk("xdrive", 64'h1 << 6'h1b, xd);
		chk("ydrive", 64'h1 << 6'h29, yd);
		wait_done(n);
		chk("length", 1, n > 80 && n < 106);
		chk("strobes", 1, n_strobe);
		chk("sync_at_strobe", 1, sync_at_str);
		chk("buffer", 16'hedcb, dut_d);
		chk("inhibit", 16'hedcb, inh_seen);
	endtask : t_read
	task automatic t_write();
		int n;
		clr();
		sense = 16'hffff;
		i_cpu.start(15'h0321, 1'b1, 16'h5aa5, 1'b0);
		wait_done(n);
		chk("strobes", 0, n_strobe);
		chk("buffer", 16'h5aa5, dut_d);
		chk("inhibit", 16'h5aa5, inh_seen);
		i_cpu.put(1'b0, 16'h0000);
	endtask : t_write
	task automatic t_rmw();
		int n;
		clr();
		sense = 16'h00f0;
		i_cpu.start(15'h0777, 1'b0, 16'h0000, 1'b1);
		step(250);
		chk("paused", 0, wd_seen);
		chk("wait_oe", 0, wt_oe_n);
		chk("buffer", 16'hff0f, dut_d);
		chk("data_oe", 0, doe_n);
		i_cpu.finish(1'b1, 16'h3c3c);
		wait_done(n);
		chk("resumed", 1, wd_seen);
		chk("buffer", 16'h3c3c, dut_d);
		chk("inhibit", 16'h3c3c, inh_seen);
		i_cpu.put(1'b0, 16'h0000);
	endtask : t_rmw
	task automatic t_sel(input logic [14:0] a, input logic b, input logic f, input logic o, input logic e);
		int n;
		blk = b;
		frc = f;
		other_n = o;
		i_cpu.start(a, 1'b0, 16'h0000, 1'b0);
		step(2);
		chk("sync", !e, sync_n);
		wait_done(n);
		blk = 1'b0;
		frc = 1'b0;
		other_n = 1'b1;
	endtask : t_sel
	task automatic t_buf();
		i_cpu.put(1'b1, 16'h9669);
		dld = 1'b1;
		step(2);
		dld = 1'b0;
		step(1);
		chk("buffer", 16'h9669, dut_d);
		chk("sync", 1, sync_n);
		lblk = 1'b1;
		i_cpu.put(1'b1, 16'h1111);
		dld = 1'b1;
		step(2);
		dld = 1'b0;
		step(1);
		chk("buffer", 16'h9669, dut_d);
		lblk = 1'b0;
		i_cpu.put(1'b0, 16'h0000);
	endtask : t_buf
	task automatic finish_test();
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : finish_test
	initial
	begin
		arst_n = 1'b0;
		step(10);
		arst_n = 1'b1;
		step(1);
		t_reset();
		t_read();
		t_write();
		t_rmw();
		t_sel(15'h1000, 1'b0, 1'b0, 1'b1, 1'b0);
		t_sel(15'h4000, 1'b0, 1'b0, 1'b1, 1'b0);
		t_sel(15'h0fff, 1'b1, 1'b0, 1'b1, 1'b0);
		t_sel(15'h7000, 1'b0, 1'b1, 1'b1, 1'b1);
		t_sel(15'h0123, 1'b0, 1'b0, 1'b0, 1'b0);
		t_sel(15'h0fff, 1'b0, 1'b0, 1'b1, 1'b1);
		t_buf();
		finish_test();
	end
endmodule : cmc_core_test
